/* File: hw/flash_erase_write_sequencer.v */
/*
 * Flash erase/write command sequencer with an APB register slave.
 * Assumes an APB master on pclk and an external flash array driven via
 * the flash_* outputs, which reports failures on flash_fail.
 */
// Behaviour
// - Data erase clears 512-byte blocks; write programs one 32-bit word.
// - Data flash pointers are offsets from base 0x9000.
// - Command starts on code in bits 2..0 with bit 7 set.
// - CPU is stalled while code flash is being reprogrammed.
// - Further commands are accepted while the mode stays selected.
// - Hardware sets done flag bit 6 when a command finishes.
// - Lower status reports write failure bit 1, erase failure bit 0.
// - Hardware clears done after start bit is cleared.
// - Status registers read-only, reset zero; bit 4 is sequencer fault.
// - Code 1 is write, 4 is erase, others invalid.
// - Code flash erase clears 1-Kbyte blocks.
`timescale 1ns/1ps
`include "flash_seq_defs.vh"

module flash_erase_write_sequencer #(
    parameter ADDR_W = 15,
    parameter CLK_NS = `CLK_PERIOD_NS
)
(
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Flash array
    output reg flash_write,
    output reg flash_erase,
    output reg flash_data_area,
    output reg [ADDR_W-1:0] flash_addr,
    output reg [31:0] flash_wdata,
    input wire flash_fail,
    // CPU
    output wire cpu_stall
);

    // ==========================================================
    // Derived timing
    localparam [15:0] WRITE_CYC = (`WRITE_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam [15:0] ERASE_CYC = (`ERASE_TIME_NS + CLK_NS - 1) / CLK_NS;

    localparam [1:0] S_IDLE = 2'd0;
    localparam [1:0] S_BUSY = 2'd1;
    localparam [1:0] S_DONE = 2'd2;

    // ==========================================================
    // Registers
    reg [7:0] prog_mode_ctl;
    reg [ADDR_W-1:0] start_ptr;
    reg [ADDR_W-1:0] end_ptr;
    reg [31:0] wbuf;
    reg [7:0] command_reg;
    reg cmd_done;
    reg write_fail;
    reg erase_fail;
    reg sequencer_fault;
    reg [1:0] state;
    reg [15:0] timer;
    reg [2:0] active_cmd;
    reg fail_seen;
    reg fail_meta;
    reg fail_sync;
    reg [31:0] next_prdata;

    // Offset bits inside one erase block of the given area
    function [ADDR_W-1:0] mask_of;
        input data_area;
        begin
            if (data_area)
                mask_of = ~({ADDR_W{1'b1}} << `DATA_BLOCK_SHIFT);
            else
                mask_of = ~({ADDR_W{1'b1}} << `CODE_BLOCK_SHIFT);
        end
    endfunction

    wire area_select = prog_mode_ctl[`AREA_SELECT_BIT];
    wire mode_ok = (prog_mode_ctl == `MODE_CODE) || (prog_mode_ctl == `MODE_DATA);
    wire wr_en = psel && penable && pwrite;
    wire cmd_go = command_reg[`CMD_GO_BIT];
    wire [2:0] cmd_code = command_reg[2:0];
    // The first block takes the area now selected; later blocks of a range take
    // the area latched at start, so a mode write mid-erase cannot skew them
    wire [ADDR_W-1:0] start_mask = mask_of(area_select);
    wire [ADDR_W-1:0] block_mask = mask_of(flash_data_area);

    function is_addr;
        input [11:0] a;
        input [11:0] off;
        begin
            is_addr = (a == off);
        end
    endfunction

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    // Stall covers any pending code flash command, not data flash
    assign cpu_stall = (state == S_BUSY) && !flash_data_area;

    // ==========================================================
    // Software-writable registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prog_mode_ctl <= `MODE_IDLE;
            start_ptr <= {ADDR_W{1'b0}};
            end_ptr <= {ADDR_W{1'b0}};
            wbuf <= 32'h00000000;
            command_reg <= 8'h00;
        end
        else if (wr_en)
        begin
            if (is_addr(paddr, `OFF_PROG_MODE_CTL))
                prog_mode_ctl <= pwdata[7:0];
            if (is_addr(paddr, `OFF_START_PTR_LOW))
                start_ptr[7:0] <= pwdata[7:0];
            if (is_addr(paddr, `OFF_START_PTR_HIGH))
                start_ptr[ADDR_W-1:8] <= pwdata[ADDR_W-9:0];
            if (is_addr(paddr, `OFF_END_PTR_LOW))
                end_ptr[7:0] <= {pwdata[7:2], 2'b00};
            if (is_addr(paddr, `OFF_END_PTR_HIGH))
                end_ptr[ADDR_W-1:8] <= pwdata[ADDR_W-9:0];
            if (is_addr(paddr, `OFF_WBUF_BYTE0))
                wbuf[7:0] <= pwdata[7:0];
            if (is_addr(paddr, `OFF_WBUF_BYTE1))
                wbuf[15:8] <= pwdata[7:0];
            if (is_addr(paddr, `OFF_WBUF_BYTE2))
                wbuf[23:16] <= pwdata[7:0];
            if (is_addr(paddr, `OFF_WBUF_BYTE3))
                wbuf[31:24] <= pwdata[7:0];
            if (is_addr(paddr, `OFF_COMMAND_REG))
                command_reg <= {pwdata[7], 4'h0, pwdata[2:0]};
        end
    end

    // ==========================================================
    // Failure input from the flash array
    // The array answers on its own timing, so its level is resynchronised;
    // a failure raised only in the last two cycles of an operation is lost
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fail_meta <= 1'b0;
            fail_sync <= 1'b0;
        end
        else
        begin
            fail_meta <= flash_fail;
            fail_sync <= fail_meta;
        end
    end

    // ==========================================================
    // Sequencer
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= S_IDLE;
            timer <= 16'h0000;
            active_cmd <= `CMD_NONE;
            cmd_done <= 1'b0;
            write_fail <= 1'b0;
            erase_fail <= 1'b0;
            sequencer_fault <= 1'b0;
            fail_seen <= 1'b0;
            flash_write <= 1'b0;
            flash_erase <= 1'b0;
            flash_data_area <= 1'b0;
            flash_addr <= {ADDR_W{1'b0}};
            flash_wdata <= 32'h00000000;
        end
        else
        begin
            flash_write <= 1'b0;
            flash_erase <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    if (cmd_go)
                    begin
                        write_fail <= 1'b0;
                        erase_fail <= 1'b0;
                        sequencer_fault <= 1'b0;
                        fail_seen <= 1'b0;
                        active_cmd <= cmd_code;
                        flash_data_area <= area_select;
                        if (!mode_ok || (cmd_code != `CMD_WRITE && cmd_code != `CMD_ERASE)
                            || (cmd_code == `CMD_WRITE && start_ptr[1:0] != 2'b00)
                            || (cmd_code == `CMD_ERASE && end_ptr < start_ptr))
                        begin
                            sequencer_fault <= 1'b1;
                            cmd_done <= 1'b1;
                            state <= S_DONE;
                        end
                        else if (cmd_code == `CMD_WRITE)
                        begin
                            flash_addr <= start_ptr;
                            flash_wdata <= wbuf;
                            flash_write <= 1'b1;
                            timer <= WRITE_CYC;
                            state <= S_BUSY;
                        end
                        else
                        begin
                            flash_addr <= start_ptr & ~start_mask;
                            flash_erase <= 1'b1;
                            timer <= ERASE_CYC;
                            state <= S_BUSY;
                        end
                    end
                end
                S_BUSY:
                begin
                    if (fail_sync)
                        fail_seen <= 1'b1;
                    if (timer > 16'h0001)
                        timer <= timer - 16'h0001;
                    else if (active_cmd == `CMD_ERASE &&
                        (flash_addr | block_mask) < end_ptr && !(fail_seen || fail_sync))
                    begin
                        // Next block of the range
                        flash_addr <= (flash_addr | block_mask) + 1'b1;
                        flash_erase <= 1'b1;
                        timer <= ERASE_CYC;
                    end
                    else
                    begin
                        write_fail <= (active_cmd == `CMD_WRITE) &&
                            (fail_seen || fail_sync);
                        erase_fail <= (active_cmd == `CMD_ERASE) && (fail_seen || fail_sync);
                        cmd_done <= 1'b1;
                        state <= S_DONE;
                    end
                end
                S_DONE:
                begin
                    if (!cmd_go)
                    begin
                        cmd_done <= 1'b0;
                        state <= S_IDLE;
                    end
                end
                default:
                    state <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Read path
    always @*
    begin
        next_prdata = 32'h00000000;
        case (paddr)
            `OFF_PROG_MODE_CTL: next_prdata[7:0] = prog_mode_ctl;
            `OFF_START_PTR_LOW: next_prdata[7:0] = start_ptr[7:0];
            `OFF_START_PTR_HIGH: next_prdata[ADDR_W-9:0] = start_ptr[ADDR_W-1:8];
            `OFF_END_PTR_LOW: next_prdata[7:0] = end_ptr[7:0];
            `OFF_END_PTR_HIGH: next_prdata[ADDR_W-9:0] = end_ptr[ADDR_W-1:8];
            `OFF_WBUF_BYTE0: next_prdata[7:0] = wbuf[7:0];
            `OFF_WBUF_BYTE1: next_prdata[7:0] = wbuf[15:8];
            `OFF_WBUF_BYTE2: next_prdata[7:0] = wbuf[23:16];
            `OFF_WBUF_BYTE3: next_prdata[7:0] = wbuf[31:24];
            `OFF_COMMAND_REG: next_prdata[7:0] = command_reg;
            `OFF_STATUS_HIGH: next_prdata[`CMD_DONE_BIT] = cmd_done;
            `OFF_ERROR_FLAGS:
            begin
                next_prdata[`SEQ_FAULT_BIT] = sequencer_fault;
                next_prdata[`WRITE_FAIL_BIT] = write_fail;
                next_prdata[`ERASE_FAIL_BIT] = erase_fail;
            end
            default: next_prdata = 32'h00000000;
        endcase
    end

    // ==========================================================
    // Read data register
    // Loaded in the setup phase so that it stands through the access phase
    // with no wait state; status is thus sampled one cycle before the access
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel && !penable)
            prdata <= next_prdata;
    end

endmodule // flash_erase_write_sequencer

/* File: hw/flash_seq_defs.vh */
/*
 * Register offsets, field positions, command codes and operation times of the
 * flash erase/write sequencer. Assumes inclusion by the sequencer module only.
 */
`ifndef FLASH_SEQ_DEFS_VH
`define FLASH_SEQ_DEFS_VH

// ==========================================================
// Register byte offsets on APB
`define OFF_PROG_MODE_CTL 12'h000
`define OFF_START_PTR_LOW 12'h004
`define OFF_START_PTR_HIGH 12'h008
`define OFF_END_PTR_LOW 12'h00c
`define OFF_END_PTR_HIGH 12'h010
`define OFF_WBUF_BYTE0 12'h014
`define OFF_WBUF_BYTE1 12'h018
`define OFF_WBUF_BYTE2 12'h01c
`define OFF_WBUF_BYTE3 12'h020
`define OFF_COMMAND_REG 12'h024
`define OFF_STATUS_HIGH 12'h028
`define OFF_ERROR_FLAGS 12'h02c

// ==========================================================
// Mode values and fields
`define MODE_IDLE 8'h00
`define MODE_CODE 8'h02
`define MODE_DATA 8'h22
`define AREA_SELECT_BIT 5
`define CMD_GO_BIT 7
`define CMD_DONE_BIT 6
`define WRITE_FAIL_BIT 1
`define ERASE_FAIL_BIT 0
`define SEQ_FAULT_BIT 4
`define CMD_NONE 3'h0
`define CMD_WRITE 3'h1
`define CMD_ERASE 3'h4

// ==========================================================
// Erase units in bytes, and per-unit operation times
`define DATA_BLOCK_BYTES 10'd512
`define DATA_BLOCK_SHIFT 9
`define CODE_BLOCK_SHIFT 10
`define WORD_BYTES 4
`define WRITE_TIME_NS 1000
`define ERASE_TIME_NS 2000
`define CLK_PERIOD_NS 10

`endif

/* File: testbench/seq_checker_asserts.sv */
/* Port checker for the flash sequencer.
   Assumes it is bound to the sequencer top module. */
`timescale 1ns/1ps
module seq_checker #(parameter ADDR_W = 15)
(
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Flash and CPU
    input wire flash_write,
    input wire flash_erase,
    input wire flash_data_area,
    input wire [ADDR_W-1:0] flash_addr,
    input wire cpu_stall
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd = psel && penable && !pwrite;
    // ==========================================
    // Properties
    property p_wr_pulse; flash_write |=> !flash_write; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
    property p_er_pulse; flash_erase |=> !flash_erase; endproperty
    a_er_pulse: assert property (p_er_pulse) else $error("erase pulse too long");
    property p_align; flash_write |-> flash_addr[1:0] == 2'h0; endproperty
    a_align: assert property (p_align) else $error("unaligned word write");
    property p_blk;
        flash_erase |-> (flash_data_area ? flash_addr[8:0] == 9'h0 : flash_addr[9:0] == 10'h0);
    endproperty
    a_blk: assert property (p_blk) else $error("erase not block aligned");
    property p_excl; !(flash_write && flash_erase); endproperty
    a_excl: assert property (p_excl) else $error("write and erase together");
    property p_stall; cpu_stall |-> !flash_data_area; endproperty
    a_stall: assert property (p_stall) else $error("stall on data area");
    property p_stall_hold; $rose(cpu_stall) |-> cpu_stall [*8]; endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("stall dropped early");
    property p_sta_hi; rd && paddr == 12'h028 |-> (prdata & ~32'h40) == 32'h0; endproperty
    a_sta_hi: assert property (p_sta_hi) else $error("status high spare bit set");
    property p_sta_lo; rd && paddr == 12'h02c |-> (prdata & ~32'h13) == 32'h0; endproperty
    a_sta_lo: assert property (p_sta_lo) else $error("error flags spare bit set");
    property p_ready; psel |-> pready && !pslverr; endproperty
    a_ready: assert property (p_ready) else $error("bus wait or error");
    cover property (flash_erase && flash_data_area);
    cover property (flash_write && cpu_stall);
    cover property (rd && paddr == 12'h02c && prdata[4]);
endmodule // seq_checker

bind flash_erase_write_sequencer seq_checker #(.ADDR_W(ADDR_W)) chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_write(flash_write),
    .flash_erase(flash_erase), .flash_data_area(flash_data_area),
    .flash_addr(flash_addr), .cpu_stall(cpu_stall));

/* File: testbench/tb_flash_erase_write_sequencer.sv */
/* Self-checking bench for the flash sequencer over APB.
   Assumes zero-wait APB and the bound port checker. */
`timescale 1ns/1ps
module tb_flash_erase_write_sequencer;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, flash_fail = 0;
    reg stall_seen = 0, last_area = 0;
    reg [11:0] paddr = 12'h0;
    reg [31:0] pwdata = 32'h0, st = 32'hec8b, r, wd, a;
    reg [14:0] last_addr;
    reg [31:0] last_data;
    wire [31:0] prdata, flash_wdata;
    wire [14:0] flash_addr;
    wire pready, pslverr, flash_write, flash_erase, flash_data_area, cpu_stall;
    integer bad_count = 0, check_count = 0, pulses = 0, i, j;
    always #5 pclk = ~pclk;
    flash_erase_write_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_write(flash_write),
        .flash_erase(flash_erase), .flash_data_area(flash_data_area),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_fail(flash_fail),
        .cpu_stall(cpu_stall));
    // ==========================================
    // Flash side monitor
    always @(posedge pclk)
    begin
        if (flash_write || flash_erase)
        begin
            pulses = pulses + 1;
            last_addr = flash_addr;
            last_data = flash_wdata;
            last_area = flash_data_area;
        end
        if (cpu_stall)
            stall_seen = 1;
    end
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [31:0] blocks(input [31:0] s, input [31:0] e, input integer sh);
        blocks = (e >> sh) - (s >> sh) + 1;
    endfunction
    // ==========================================
    // Tasks
    task check(input string n, input [31:0] seen, input [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task apb(input w, input [11:0] ad, input [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    task poll(input v);
        i = 0;
        apb(0, 12'h028, 0);
        while (r[6] !== v && i < 500)
        begin
            apb(0, 12'h028, 0);
            i = i + 1;
        end
        check("cmd_done", r, {25'h0, v, 6'h0});
    endtask
    task ptrs(input [31:0] s, input [31:0] e);
        apb(1, 12'h004, s & 32'hff);
        apb(1, 12'h008, s >> 8);
        apb(1, 12'h00c, e & 32'hff);
        apb(1, 12'h010, e >> 8);
    endtask
    // Full handshake: start, wait done, read flags, drop start, wait clear
    task run(input [7:0] code, input [31:0] err);
        pulses = 0;
        apb(1, 12'h024, {24'h0, code});
        poll(1);
        apb(0, 12'h02c, 0);
        check("error_flags", r, err);
        apb(1, 12'h024, 0);
        poll(0);
    endtask
    task test_done;
        if (bad_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h028, 0);
        check("status_high", r, 0);
        apb(0, 12'h02c, 0);
        check("error_flags", r, 0);
        apb(0, 12'h030, 0);
        check("unmapped", r, 0);
        apb(1, 12'h000, 32'h02);
        for (j = 0; j < 3; j = j + 1)
        begin
            st = lfsr(st);
            a = st & 32'h7ffc;
            st = lfsr(st);
            wd = st;
            ptrs(a, 0);
            apb(1, 12'h014, {24'h0, wd[7:0]});
            apb(1, 12'h018, {24'h0, wd[15:8]});
            apb(1, 12'h01c, {24'h0, wd[23:16]});
            apb(1, 12'h020, {24'h0, wd[31:24]});
            run(8'h81, 0);
            check("pulses", pulses, 1);
            check("addr", last_addr, a);
            check("wdata", last_data, wd);
        end
        check("stall", stall_seen, 1);
        check("area", last_area, 0);
        flash_fail <= 1;
        run(8'h81, 32'h02);
        ptrs(32'h0400, 32'h07ff);
        run(8'h84, 32'h01);
        flash_fail <= 0;
        ptrs(32'h0800, 32'h0bff);
        run(8'h84, 0);
        check("pulses", pulses, blocks(32'h0800, 32'h0bff, 10));
        check("addr", last_addr, 32'h0800);
        ptrs(32'h0802, 0);
        run(8'h81, 32'h10);
        run(8'h82, 32'h10);
        check("pulses", pulses, 0);
        apb(1, 12'h000, 32'h22);
        stall_seen = 0;
        ptrs(32'h0000, 32'h03ff);
        run(8'h84, 0);
        check("pulses", pulses, blocks(0, 32'h03ff, 9));
        check("addr", last_addr, 32'h0200);
        check("area", last_area, 1);
        ptrs(32'h01fc, 0);
        run(8'h81, 0);
        check("addr", last_addr, 32'h01fc);
        check("stall", stall_seen, 0);
        apb(1, 12'h000, 32'h00);
        run(8'h81, 32'h10);
        test_done;
    end
    initial
    begin
        #900000;
        bad_count = bad_count + 1;
        test_done;
    end
endmodule // tb_flash_erase_write_sequencer
